// ---- rtl/mac_pkg.sv ----
package mac_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_M = 3;
  localparam int NUM_BANKS = 4;
  localparam int M_CPU = 0;
  localparam int M_DRD = 1;
  localparam int M_DWR = 2;

  // address map of the data space, region in addr[15:12]
  localparam logic [3:0] REGION_EE = 4'h1;
  localparam logic [3:0] REGION_SR = 4'h2;
  localparam int SR_SET_BIT = 11;

  typedef enum logic [1:0] {
    BANK_IO = 2'h0,
    BANK_EE = 2'h1,
    BANK_SR0 = 2'h2,
    BANK_SR1 = 2'h3
  } mac_bank_e;

  typedef enum logic {
    ST_IDLE = 1'h0,
    ST_BUSY = 1'h1
  } mac_bank_st_e;

  typedef enum logic [1:0] {
    NVM_NONE = 2'h0,
    NVM_FL_PAGE = 2'h1,
    NVM_EE_PAGE = 2'h2,
    NVM_EE_BYTE = 2'h3
  } mac_nvm_e;

  // access timing in clock cycles
  localparam int IO_RD_LAT = 1;
  localparam int SR_RD_LAT = 2;
  localparam int EE_RD_LAT = 3;
  localparam int IO_BURST_GAP = 1;
  localparam int SR_BURST_GAP = 1;
  localparam int EE_BURST_GAP = 2;

  // I/O offsets
  localparam logic [11:0] IO_ID0_OFS = 12'h000;
  localparam logic [11:0] IO_ID1_OFS = 12'h001;
  localparam logic [11:0] IO_ID2_OFS = 12'h002;
  localparam logic [11:0] IO_REV_OFS = 12'h003;
  localparam logic [11:0] IO_LOCK_OFS = 12'h004;
  localparam logic [11:0] IO_CLK_BASE = 12'h008;
  localparam logic [11:0] IO_EVT_BASE = 12'h010;
  localparam logic [11:0] IO_WEX_BASE = 12'h018;
  localparam int IO_GRP_BITS = 3;
  localparam int LOCK_CLK_BIT = 0;
  localparam int LOCK_EVT_BIT = 1;
  localparam int LOCK_WEX_BIT = 2;
  localparam logic [2:0] LOCK_RST = 3'h0;

  // flash pointer layout
  localparam int FLASH_WORD_IN_PAGE_LSB = 0;
  localparam int FLASH_WORD_IN_PAGE_W = 7;
  localparam int FLASH_PAGE_NUMBER_LSB = 7;
  localparam int FLASH_PAGE_NUMBER_W = 8;
  localparam int PC_W = 15;
  localparam int APP_PAGES = 128;
  localparam int BOOT_PAGES = 16;
endpackage

// ---- rtl/mac_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module mac_bank
  import mac_pkg::*;
#(
  parameter int RD_LAT = 2,
  parameter int GAP = 1,
  parameter int AW = 16
) (
  input wire logic core_clk_i, // clock
  input wire logic rst_n_i, // async reset, low
  input wire logic en_i, // clock enable
  input wire logic start_i, // start an access
  input wire logic start_we_i, // access is a write
  input wire logic [AW-1:0] start_addr_i, // first address
  input wire logic [3:0] start_len_i, // read beats, 0 = 1
  input wire logic [1:0] start_own_i, // requesting master
  output logic idle_o, // ready for a start
  output logic fire_o, // a beat completes this cycle
  output logic fire_we_o, // completing beat is a write
  output logic fire_last_o, // final beat
  output logic [AW-1:0] fire_addr_o, // beat address
  output logic [1:0] fire_own_o // beat owner
);
  localparam logic [1:0] FIRST_WAIT = 2'(RD_LAT - 2);
  localparam logic [1:0] GAP_WAIT = 2'(GAP - 1);
  localparam int FIRST_DLY = RD_LAT - 1;

  typedef struct packed {
    mac_bank_st_e st;
    logic [1:0] cnt;
    logic [3:0] left;
    logic [AW-1:0] addr;
    logic [1:0] own;
  } mac_bank_s;

  mac_bank_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    idle_o = (s_q.st == ST_IDLE);
    fire_o = 1'b0;
    fire_we_o = 1'b0;
    fire_last_o = 1'b0;
    fire_addr_o = s_q.addr;
    fire_own_o = s_q.own;
    case (s_q.st)
      ST_IDLE: begin
        if (start_i) begin
          s_d.own = start_own_i;
          if (start_we_i || RD_LAT == 1) begin
            // single-cycle accesses finish on the start edge
            fire_o = 1'b1;
            fire_we_o = start_we_i;
            fire_addr_o = start_addr_i;
            fire_own_o = start_own_i;
            fire_last_o = start_we_i || (start_len_i <= 4'h1);
            if (!fire_last_o) begin
              s_d.st = ST_BUSY;
              s_d.cnt = GAP_WAIT;
              s_d.left = start_len_i - 4'h1;
              s_d.addr = start_addr_i + AW'(1);
            end
          end else begin
            s_d.st = ST_BUSY;
            s_d.cnt = FIRST_WAIT;
            s_d.left = (start_len_i == 4'h0) ? 4'h1 : start_len_i;
            s_d.addr = start_addr_i;
          end
        end
      end
      ST_BUSY: begin
        if (s_q.cnt == 2'h0) begin
          fire_o = 1'b1;
          fire_last_o = (s_q.left <= 4'h1);
          if (fire_last_o) begin
            s_d.st = ST_IDLE;
          end else begin
            s_d.cnt = GAP_WAIT;
            s_d.left = s_q.left - 4'h1;
            s_d.addr = s_q.addr + AW'(1);
          end
        end else begin
          s_d.cnt = s_q.cnt - 2'h1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else if (en_i) begin
      s_q <= s_d;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i || !en_i);

  sequence s_rd_start;
    idle_o && start_i && !start_we_i;
  endsequence
  sequence s_mid_beat;
    fire_o && !fire_last_o && !fire_we_o;
  endsequence

  property p_first_beat;
    s_rd_start |-> ##FIRST_DLY fire_o;
  endproperty
  a_first_beat: assert property (p_first_beat)
    else $error("first read beat late");
  property p_wr_now;
    idle_o && start_i && start_we_i |-> fire_o && fire_last_o;
  endproperty
  a_wr_now: assert property (p_wr_now)
    else $error("write did not finish in one cycle");
  property p_burst_gap;
    s_mid_beat |-> ##GAP fire_o;
  endproperty
  a_burst_gap: assert property (p_burst_gap)
    else $error("burst beat spacing wrong");
endmodule
`default_nettype wire

// ---- rtl/mac_mem_access.sv ----
`timescale 1ns/1ps
`default_nettype none
module mac_mem_access
  import mac_pkg::*;
#(
  parameter int IO_DEPTH = 64,
  parameter int SR_DEPTH = 4096,
  parameter int EE_DEPTH = 1024,
  parameter int EE_PAGE_BITS = 5,
  parameter logic [23:0] DEV_ID = 24'h5A_C3_11, // arbitrary value
  parameter logic [7:0] REV_ID = 8'h0A // arbitrary value
) (
  input wire logic core_clk_i, // 25 MHz clock
  input wire logic rst_n_i, // async reset, low
  input wire logic en_i, // clock enable, freezes all
  input wire logic cpu_req_i, // cpu access strobe
  input wire logic cpu_we_i, // cpu write
  input wire logic [15:0] cpu_addr_i, // cpu address
  input wire logic [7:0] cpu_wdata_i, // cpu write data
  output logic cpu_ready_o, // cpu may strobe
  output logic cpu_done_o, // cpu access finished
  output logic [7:0] cpu_rdata_o, // cpu read data
  input wire logic dma_rd_req_i, // dma read strobe
  input wire logic [15:0] dma_rd_addr_i, // dma read start address
  input wire logic [3:0] dma_rd_len_i, // burst beats, 0 = 1
  output logic dma_rd_ready_o, // dma read may strobe
  output logic dma_rd_done_o, // one beat delivered
  output logic dma_rd_last_o, // beat is the final one
  output logic [7:0] dma_rd_rdata_o, // beat data
  input wire logic dma_wr_req_i, // dma write strobe
  input wire logic [15:0] dma_wr_addr_i, // dma write address
  input wire logic [7:0] dma_wr_wdata_i, // dma write data
  output logic dma_wr_ready_o, // dma write may strobe
  output logic dma_wr_done_o, // dma write finished
  input wire logic ccp_open_i, // protection unlock window open
  input wire logic nvm_go_i, // start nvm operation
  input wire logic [1:0] nvm_cmd_i, // nvm operation kind
  input wire logic [15:0] flash_ptr_i, // flash index pointer
  input wire logic [$clog2(EE_DEPTH)-1:0] nvm_addr_i, // nvm address
  output logic [FLASH_PAGE_NUMBER_W-1:0] flash_page_number_o, // flash page
  output logic [FLASH_WORD_IN_PAGE_W-1:0] flash_word_in_page_o, // word in page
  output logic flash_boot_o, // page lies in or past the boot area
  output logic flash_op_o, // whole-page flash operation
  output logic [$clog2(EE_DEPTH)-EE_PAGE_BITS-1:0] eeprom_page_number_o, // pg
  output logic [EE_PAGE_BITS-1:0] eeprom_byte_in_page_o, // byte in page
  output logic eeprom_op_o, // eeprom operation pulse
  output logic eeprom_whole_page_o // operation covers the page
);
  localparam int EE_AW = $clog2(EE_DEPTH);
  localparam int SR_AW = $clog2(SR_DEPTH);
  localparam int IO_AW = $clog2(IO_DEPTH);
  localparam int EPW = EE_AW - EE_PAGE_BITS;

  typedef struct packed {
    logic [NUM_M-1:0] pend;
    logic [NUM_M-1:0] busy;
    logic [NUM_M-1:0] ready;
    logic [NUM_M-1:0] done;
    logic [NUM_M-1:0] last;
    logic [NUM_M-1:0] p_we;
    logic [NUM_M-1:0][15:0] p_addr;
    logic [NUM_M-1:0][7:0] p_wd;
    logic [NUM_M-1:0][3:0] p_len;
    logic [NUM_M-1:0][7:0] rdata;
    logic [2:0] lock;
    logic [FLASH_PAGE_NUMBER_W-1:0] flash_page_number;
    logic [FLASH_WORD_IN_PAGE_W-1:0] flash_word_in_page;
    logic fboot;
    logic fop;
    logic [EPW-1:0] epage;
    logic [EE_PAGE_BITS-1:0] ebyte;
    logic eop;
    logic ewhole;
  } mac_top_s;

  mac_top_s s_q, s_d;
  logic [7:0] io_mem [IO_DEPTH];
  logic [7:0] sr_mem [SR_DEPTH];
  logic [7:0] ee_mem [EE_DEPTH];

  logic [NUM_M-1:0] lv_req, lv_we, ev, e_we, taken;
  logic [NUM_M-1:0][15:0] lv_addr, e_addr;
  logic [NUM_M-1:0][7:0] lv_wd, e_wd;
  logic [NUM_M-1:0][3:0] lv_len, e_len;
  logic [NUM_M-1:0][1:0] e_bank;
  logic [NUM_BANKS-1:0] b_go, b_idle, b_fire, b_we, b_last;
  logic [NUM_BANKS-1:0][1:0] b_own, f_own;
  logic [NUM_BANKS-1:0][15:0] f_addr;
  logic [NUM_BANKS-1:0][7:0] b_wd, f_rd;
  logic [11:0] io_ofs;
  logic io_wr_ok, lock_wr;

  assign lv_req = {dma_wr_req_i, dma_rd_req_i, cpu_req_i};
  assign lv_we = {1'b1, 1'b0, cpu_we_i};
  assign lv_addr = {dma_wr_addr_i, dma_rd_addr_i, cpu_addr_i};
  assign lv_wd = {dma_wr_wdata_i, 8'h00, cpu_wdata_i};
  assign lv_len = {4'h1, dma_rd_len_i, 4'h1};

  function automatic logic [1:0] bank_of(input logic [15:0] a);
    if (a[15:12] == REGION_EE) begin
      bank_of = BANK_EE;
    end else if (a[15:12] == REGION_SR) begin
      bank_of = a[SR_SET_BIT] ? BANK_SR1 : BANK_SR0;
    end else begin
      bank_of = BANK_IO;
    end
  endfunction

  function automatic logic in_grp(input logic [11:0] o, input logic [11:0] b);
    in_grp = (o[11:IO_GRP_BITS] == b[11:IO_GRP_BITS]);
  endfunction

  // locked groups, identity and revision never take a write
  function automatic logic io_wr_allowed(input logic [11:0] o,
                                         input logic [2:0] lk);
    io_wr_allowed = !((lk[LOCK_CLK_BIT] && in_grp(o, IO_CLK_BASE)) ||
                      (lk[LOCK_EVT_BIT] && in_grp(o, IO_EVT_BASE)) ||
                      (lk[LOCK_WEX_BIT] && in_grp(o, IO_WEX_BASE)) ||
                      (o <= IO_LOCK_OFS) || (o >= 12'(IO_DEPTH)));
  endfunction

  // current request of each master: held one, else a fresh strobe
  always_comb begin
    for (int m = 0; m < NUM_M; m++) begin
      ev[m] = s_q.pend[m] | (lv_req[m] & s_q.ready[m]);
      e_we[m] = s_q.pend[m] ? s_q.p_we[m] : lv_we[m];
      e_addr[m] = s_q.pend[m] ? s_q.p_addr[m] : lv_addr[m];
      e_wd[m] = s_q.pend[m] ? s_q.p_wd[m] : lv_wd[m];
      e_len[m] = s_q.pend[m] ? s_q.p_len[m] : lv_len[m];
      e_bank[m] = bank_of(e_addr[m]);
    end
  end

  // per-set fixed priority, cpu first; other sets run in parallel
  always_comb begin
    b_go = '0;
    b_own = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      for (int m = NUM_M - 1; m >= 0; m--) begin
        if (ev[m] && e_bank[m] == 2'(b) && b_idle[b]) begin
          b_go[b] = 1'b1;
          b_own[b] = 2'(m);
        end
      end
      b_wd[b] = e_wd[b_own[b]];
    end
    for (int m = 0; m < NUM_M; m++) begin
      taken[m] = ev[m] && b_go[e_bank[m]] && b_own[e_bank[m]] == 2'(m);
    end
  end

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_set
    localparam int LAT = (b == BANK_IO) ? IO_RD_LAT :
                         (b == BANK_EE) ? EE_RD_LAT : SR_RD_LAT;
    localparam int GP = (b == BANK_IO) ? IO_BURST_GAP :
                        (b == BANK_EE) ? EE_BURST_GAP : SR_BURST_GAP;
    mac_bank #(.RD_LAT(LAT), .GAP(GP), .AW(16)) u_bank (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .en_i(en_i),
      .start_i(b_go[b]),
      .start_we_i(e_we[b_own[b]]),
      .start_addr_i(e_addr[b_own[b]]),
      .start_len_i(e_len[b_own[b]]),
      .start_own_i(b_own[b]),
      .idle_o(b_idle[b]),
      .fire_o(b_fire[b]),
      .fire_we_o(b_we[b]),
      .fire_last_o(b_last[b]),
      .fire_addr_o(f_addr[b]),
      .fire_own_o(f_own[b])
    );
  end

  assign io_ofs = f_addr[BANK_IO][11:0];
  assign io_wr_ok = io_wr_allowed(io_ofs, s_q.lock);
  assign lock_wr = b_fire[BANK_IO] && b_we[BANK_IO] &&
                   io_ofs == IO_LOCK_OFS && ccp_open_i;

  // read data of the beat completing on each set
  always_comb begin
    case (io_ofs)
      IO_ID0_OFS: f_rd[BANK_IO] = DEV_ID[7:0];
      IO_ID1_OFS: f_rd[BANK_IO] = DEV_ID[15:8];
      IO_ID2_OFS: f_rd[BANK_IO] = DEV_ID[23:16];
      IO_REV_OFS: f_rd[BANK_IO] = REV_ID;
      IO_LOCK_OFS: f_rd[BANK_IO] = {5'h00, s_q.lock};
      default: f_rd[BANK_IO] = (f_addr[BANK_IO][15:12] == 4'h0 &&
                                io_ofs < 12'(IO_DEPTH)) ?
                               io_mem[io_ofs[IO_AW-1:0]] : 8'h00;
    endcase
    f_rd[BANK_EE] = ee_mem[f_addr[BANK_EE][EE_AW-1:0]];
    f_rd[BANK_SR0] = sr_mem[f_addr[BANK_SR0][SR_AW-1:0]];
    f_rd[BANK_SR1] = sr_mem[f_addr[BANK_SR1][SR_AW-1:0]];
  end

  always_comb begin
    s_d = s_q;
    s_d.done = '0;
    s_d.last = '0;
    s_d.fop = 1'b0;
    s_d.eop = 1'b0;
    for (int m = 0; m < NUM_M; m++) begin
      if (taken[m]) begin
        s_d.pend[m] = 1'b0;
        s_d.busy[m] = 1'b1;
      end else if (ev[m] && !s_q.pend[m]) begin
        // lost the set this cycle: hold the strobe until it wins
        s_d.pend[m] = 1'b1;
        s_d.p_we[m] = lv_we[m];
        s_d.p_addr[m] = lv_addr[m];
        s_d.p_wd[m] = lv_wd[m];
        s_d.p_len[m] = lv_len[m];
      end
    end
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (b_fire[b]) begin
        s_d.done[f_own[b]] = 1'b1;
        s_d.last[f_own[b]] = b_last[b];
        if (!b_we[b]) begin
          s_d.rdata[f_own[b]] = f_rd[b];
        end
        if (b_last[b]) begin
          s_d.busy[f_own[b]] = 1'b0;
        end
      end
    end
    if (lock_wr) begin
      s_d.lock = b_wd[BANK_IO][2:0];
    end
    s_d.ready = ~(s_d.pend | s_d.busy);
    s_d.flash_word_in_page = flash_ptr_i[FLASH_WORD_IN_PAGE_LSB +: FLASH_WORD_IN_PAGE_W];
    s_d.flash_page_number = flash_ptr_i[FLASH_PAGE_NUMBER_LSB +: FLASH_PAGE_NUMBER_W];
    s_d.fboot = s_d.flash_page_number >= FLASH_PAGE_NUMBER_W'(APP_PAGES);
    s_d.epage = nvm_addr_i[EE_AW-1:EE_PAGE_BITS];
    s_d.ebyte = nvm_addr_i[EE_PAGE_BITS-1:0];
    if (nvm_go_i) begin
      case (mac_nvm_e'(nvm_cmd_i))
        // pages past the boot area do not exist and are refused
        NVM_FL_PAGE: s_d.fop = s_d.flash_page_number <
                               FLASH_PAGE_NUMBER_W'(APP_PAGES + BOOT_PAGES);
        NVM_EE_PAGE: begin
          s_d.eop = 1'b1;
          s_d.ewhole = 1'b1;
        end
        NVM_EE_BYTE: begin
          s_d.eop = 1'b1;
          s_d.ewhole = 1'b0;
        end
        default: s_d.eop = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.ready <= '1;
      s_q.lock <= LOCK_RST;
    end else if (en_i) begin
      s_q <= s_d;
    end
  end

  // blocked writes still complete and acknowledge, they just store nothing
  always_ff @(posedge core_clk_i) begin
    if (en_i) begin
      if (b_fire[BANK_IO] && b_we[BANK_IO] && io_wr_ok &&
          f_addr[BANK_IO][15:12] == 4'h0) begin
        io_mem[io_ofs[IO_AW-1:0]] <= b_wd[BANK_IO];
      end
      if (b_fire[BANK_EE] && b_we[BANK_EE]) begin
        ee_mem[f_addr[BANK_EE][EE_AW-1:0]] <= b_wd[BANK_EE];
      end
      if (b_fire[BANK_SR0] && b_we[BANK_SR0]) begin
        sr_mem[f_addr[BANK_SR0][SR_AW-1:0]] <= b_wd[BANK_SR0];
      end
      if (b_fire[BANK_SR1] && b_we[BANK_SR1]) begin
        sr_mem[f_addr[BANK_SR1][SR_AW-1:0]] <= b_wd[BANK_SR1];
      end
    end
  end

  assign cpu_ready_o = s_q.ready[M_CPU];
  assign cpu_done_o = s_q.done[M_CPU];
  assign cpu_rdata_o = s_q.rdata[M_CPU];
  assign dma_rd_ready_o = s_q.ready[M_DRD];
  assign dma_rd_done_o = s_q.done[M_DRD];
  assign dma_rd_last_o = s_q.last[M_DRD];
  assign dma_rd_rdata_o = s_q.rdata[M_DRD];
  assign dma_wr_ready_o = s_q.ready[M_DWR];
  assign dma_wr_done_o = s_q.done[M_DWR];
  assign flash_page_number_o = s_q.flash_page_number;
  assign flash_word_in_page_o = s_q.flash_word_in_page;
  assign flash_boot_o = s_q.fboot;
  assign flash_op_o = s_q.fop;
  assign eeprom_page_number_o = s_q.epage;
  assign eeprom_byte_in_page_o = s_q.ebyte;
  assign eeprom_op_o = s_q.eop;
  assign eeprom_whole_page_o = s_q.ewhole;

  // checking helpers
  logic chk_arm_q;
  logic [IO_AW-1:0] chk_idx_q;
  logic [7:0] chk_val_q;
  logic [FLASH_PAGE_NUMBER_W-1:0] ptr_page;
  assign ptr_page = flash_ptr_i[FLASH_PAGE_NUMBER_LSB +: FLASH_PAGE_NUMBER_W];
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chk_arm_q <= 1'b0;
      chk_idx_q <= '0;
      chk_val_q <= 8'h00;
    end else if (en_i) begin
      chk_arm_q <= b_fire[BANK_IO] && b_we[BANK_IO] && !io_wr_ok &&
                   io_ofs < 12'(IO_DEPTH) && io_ofs > IO_LOCK_OFS;
      chk_idx_q <= io_ofs[IO_AW-1:0];
      chk_val_q <= io_mem[io_ofs[IO_AW-1:0]];
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i || !en_i);

  sequence s_cpu_rd(logic [1:0] bk);
    taken[M_CPU] && !e_we[M_CPU] && e_bank[M_CPU] == bk;
  endsequence

  property p_io_one;
    taken[M_CPU] && e_bank[M_CPU] == BANK_IO |=> cpu_done_o;
  endproperty
  a_io_one: assert property (p_io_one)
    else $error("io access not done in one cycle");
  property p_sr_rd;
    s_cpu_rd(BANK_SR0) |=> !cpu_done_o ##1 cpu_done_o;
  endproperty
  a_sr_rd: assert property (p_sr_rd)
    else $error("sram read not two cycles");
  property p_sr_burst;
    b_fire[BANK_SR0] && !b_last[BANK_SR0] && !b_we[BANK_SR0]
      |=> b_fire[BANK_SR0];
  endproperty
  a_sr_burst: assert property (p_sr_burst)
    else $error("sram burst beat missing");
  property p_ee_rd;
    s_cpu_rd(BANK_EE) |=> !cpu_done_o [*2] ##1 cpu_done_o;
  endproperty
  a_ee_rd: assert property (p_ee_rd)
    else $error("eeprom read not three cycles");
  property p_ee_burst;
    b_fire[BANK_EE] && !b_last[BANK_EE] && !b_we[BANK_EE]
      |=> !b_fire[BANK_EE] ##1 b_fire[BANK_EE];
  endproperty
  a_ee_burst: assert property (p_ee_burst)
    else $error("eeprom burst not every second cycle");
  property p_parallel;
    ev[M_CPU] && ev[M_DWR] && e_bank[M_CPU] != e_bank[M_DWR] &&
      b_idle[e_bank[M_CPU]] && b_idle[e_bank[M_DWR]]
      |-> taken[M_CPU] && taken[M_DWR];
  endproperty
  a_parallel: assert property (p_parallel)
    else $error("different sets not served together");
  property p_rev;
    s_cpu_rd(BANK_IO) ##0 (e_addr[M_CPU] == {4'h0, IO_REV_OFS})
      |=> cpu_rdata_o == REV_ID;
  endproperty
  a_rev: assert property (p_rev)
    else $error("revision read wrong");
  property p_lock_hold;
    chk_arm_q |-> io_mem[chk_idx_q] == chk_val_q;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("blocked write changed a register");
  property p_lock_ccp;
    $changed(s_q.lock) |-> $past(ccp_open_i);
  endproperty
  a_lock_ccp: assert property (p_lock_ccp)
    else $error("lock changed outside unlock window");
  property p_flash_page_number;
    1'b1 |=> flash_page_number_o == $past(ptr_page);
  endproperty
  a_flash_page_number: assert property (p_flash_page_number)
    else $error("flash page decode wrong");
  property p_ee_byte;
    nvm_go_i && nvm_cmd_i == NVM_EE_BYTE
      |=> eeprom_op_o && !eeprom_whole_page_o;
  endproperty
  a_ee_byte: assert property (p_ee_byte)
    else $error("eeprom byte operation wrong");
endmodule
`default_nettype wire

// ---- testbench/mac_dma_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// dma read side: one strobe per burst, raised only while ready is seen
module mac_dma_model (
  input wire logic core_clk_i, // clock
  input wire logic rst_n_i, // async reset, low
  input wire logic go_i, // bench asks for a burst
  input wire logic [15:0] addr_i, // burst start address
  input wire logic [3:0] len_i, // burst beats
  input wire logic ready_i, // design may take a strobe
  output logic req_o, // read strobe
  output logic [15:0] addr_o, // held start address
  output logic [3:0] len_o // held length
);
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o <= 1'b0;
      addr_o <= 16'h0000;
      len_o <= 4'h0;
    end else begin
      // one outstanding burst: a strobe only when the design is ready
      req_o <= go_i & ready_i & ~req_o;
      if (go_i) begin
        addr_o <= addr_i;
        len_o <= len_i;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mac_pkg::*;
  localparam logic [23:0] ID_V = 24'h3C96A5; // arbitrary
  localparam logic [7:0] RV_V = 8'h07; // arbitrary
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, cpu_req_i = 1'b0;
  logic cpu_we_i = 1'b0, ccp_open_i = 1'b0, go = 1'b0;
  logic dma_wr_req_i = 1'b0, nvm_go_i = 1'b0, en_i = 1'b1;
  logic [15:0] cpu_addr_i = 16'h0000, dma_wr_addr_i = 16'h0000;
  logic [15:0] g_addr = 16'h0000, flash_ptr_i = 16'h0000;
  logic [7:0] cpu_wdata_i = 8'h00, dma_wr_wdata_i = 8'h00, rd;
  logic [3:0] g_len = 4'h0, dma_rd_len_i;
  logic [1:0] nvm_cmd_i = 2'h0;
  logic [9:0] nvm_addr_i = 10'h000;
  logic [15:0] dma_rd_addr_i;
  logic dma_rd_req_i, cpu_ready_o, cpu_done_o, dma_rd_ready_o;
  logic dma_rd_done_o, dma_rd_last_o, dma_wr_done_o, flash_boot_o;
  logic flash_op_o, eeprom_op_o, eeprom_whole_page_o, dma_wr_ready_o;
  logic [7:0] cpu_rdata_o, dma_rd_rdata_o, flash_page_number_o;
  logic [6:0] flash_word_in_page_o;
  logic [4:0] eeprom_page_number_o, eeprom_byte_in_page_o;
  int failures = 0;
  int checks_done = 0;
  always #20 core_clk_i = ~core_clk_i;
  mac_mem_access #(.DEV_ID(ID_V), .REV_ID(RV_V)) mac_mem_access_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .en_i(en_i),
    .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_ready_o(cpu_ready_o),
    .cpu_done_o(cpu_done_o), .cpu_rdata_o(cpu_rdata_o),
    .dma_rd_req_i(dma_rd_req_i), .dma_rd_addr_i(dma_rd_addr_i),
    .dma_rd_len_i(dma_rd_len_i), .dma_rd_ready_o(dma_rd_ready_o),
    .dma_rd_done_o(dma_rd_done_o), .dma_rd_last_o(dma_rd_last_o),
    .dma_rd_rdata_o(dma_rd_rdata_o), .dma_wr_req_i(dma_wr_req_i),
    .dma_wr_addr_i(dma_wr_addr_i), .dma_wr_wdata_i(dma_wr_wdata_i),
    .dma_wr_ready_o(dma_wr_ready_o), .dma_wr_done_o(dma_wr_done_o),
    .ccp_open_i(ccp_open_i), .nvm_go_i(nvm_go_i), .nvm_cmd_i(nvm_cmd_i),
    .flash_ptr_i(flash_ptr_i), .nvm_addr_i(nvm_addr_i),
    .flash_page_number_o(flash_page_number_o),
    .flash_word_in_page_o(flash_word_in_page_o),
    .flash_boot_o(flash_boot_o), .flash_op_o(flash_op_o),
    .eeprom_page_number_o(eeprom_page_number_o),
    .eeprom_byte_in_page_o(eeprom_byte_in_page_o),
    .eeprom_op_o(eeprom_op_o), .eeprom_whole_page_o(eeprom_whole_page_o));
  mac_dma_model mac_dma_model_inst (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .go_i(go), .addr_i(g_addr), .len_i(g_len),
    .ready_i(dma_rd_ready_o), .req_o(dma_rd_req_i),
    .addr_o(dma_rd_addr_i), .len_o(dma_rd_len_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic step;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic cpu(input logic w, input logic [15:0] a,
                     input logic [7:0] d, input int lat);
    int n;
    cpu_req_i = 1'b1;
    cpu_we_i = w;
    cpu_addr_i = a;
    cpu_wdata_i = d;
    step;
    cpu_req_i = 1'b0;
    n = 1;
    while (cpu_done_o !== 1'b1 && n < 20) begin
      step;
      n++;
    end
    check(n, lat);
    rd = cpu_rdata_o;
    // let an edge pass so the next call never re-raises the strobe at once
    step;
  endtask
  task automatic t_id;
    for (int i = 0; i < 3; i++) begin
      cpu(1'b0, 16'(i), 8'h00, 1);
      check(rd, ID_V[8*i+:8]);
    end
    cpu(1'b1, 16'h0003, 8'hFF, 1);
    cpu(1'b0, 16'h0003, 8'h00, 1);
    check(rd, RV_V);
  endtask
  task automatic t_lock;
    cpu(1'b1, 16'h0008, 8'h55, 1);
    cpu(1'b1, 16'h0004, 8'h01, 1);
    cpu(1'b0, 16'h0004, 8'h00, 1);
    check(rd, 8'h00);
    ccp_open_i = 1'b1;
    cpu(1'b1, 16'h0004, 8'h01, 1);
    ccp_open_i = 1'b0;
    cpu(1'b1, 16'h0008, 8'hAA, 1);
    cpu(1'b0, 16'h0008, 8'h00, 1);
    check(rd, 8'h55);
    ccp_open_i = 1'b1;
    cpu(1'b1, 16'h0004, 8'h00, 1);
    ccp_open_i = 1'b0;
    cpu(1'b1, 16'h0008, 8'hAA, 1);
    cpu(1'b0, 16'h0008, 8'h00, 1);
    check(rd, 8'hAA);
  endtask
  task automatic t_mem;
    for (int i = 0; i < 3; i++) cpu(1'b1, 16'(16'h2100 + i), 8'(8'hA0 + i), 1);
    for (int i = 0; i < 2; i++) cpu(1'b1, 16'(16'h1040 + i), 8'(8'hB0 + i), 1);
    cpu(1'b0, 16'h2101, 8'h00, 2);
    check(rd, 8'hA1);
    cpu(1'b0, 16'h1041, 8'h00, 3);
    check(rd, 8'hB1);
  endtask
  task automatic t_burst(input logic [15:0] a, input logic [3:0] len,
                         input int lat, input int gap, input logic [7:0] b);
    int k;
    go = 1'b1;
    g_addr = a;
    g_len = len;
    step;
    go = 1'b0;
    k = 0;
    for (int n = 1; n <= 12; n++) begin
      step;
      if (n == 1) check(dma_rd_ready_o, 1'b0);
      if (dma_rd_done_o === 1'b1) begin
        check(n, lat + k * gap);
        check(dma_rd_rdata_o, 8'(b + k));
        check(dma_rd_last_o, k == len - 1);
        k++;
      end
    end
    check(k, len);
    check(dma_rd_ready_o, 1'b1);
  endtask
  task automatic t_conc;
    cpu_req_i = 1'b1;
    cpu_we_i = 1'b1;
    cpu_addr_i = 16'h2004;
    cpu_wdata_i = 8'h5A;
    dma_wr_req_i = 1'b1;
    dma_wr_addr_i = 16'h000A;
    dma_wr_wdata_i = 8'h3C;
    step;
    cpu_req_i = 1'b0;
    dma_wr_req_i = 1'b0;
    check({cpu_done_o, dma_wr_done_o, dma_wr_ready_o}, 3'h7);
    step;
    // same set: the cpu wins, the dma write waits one cycle
    cpu_req_i = 1'b1;
    cpu_addr_i = 16'h000B;
    dma_wr_req_i = 1'b1;
    step;
    cpu_req_i = 1'b0;
    dma_wr_req_i = 1'b0;
    check({cpu_done_o, dma_wr_done_o, dma_wr_ready_o}, 3'h4);
    step;
    check({dma_wr_done_o, dma_wr_ready_o}, 2'h3);
    cpu(1'b0, 16'h000A, 8'h00, 1);
    check(rd, 8'h3C);
  endtask
  task automatic t_en;
    cpu_req_i = 1'b1;
    cpu_we_i = 1'b0;
    cpu_addr_i = 16'h2102;
    step;
    cpu_req_i = 1'b0;
    en_i = 1'b0;
    repeat (3) step;
    check({cpu_ready_o, cpu_done_o}, 2'h0);
    en_i = 1'b1;
    step;
    check({cpu_ready_o, cpu_done_o, cpu_rdata_o}, 10'h3A2);
  endtask
  task automatic t_nvm(input logic [1:0] c, input logic [15:0] p,
                       input logic [9:0] a);
    nvm_go_i = 1'b1;
    nvm_cmd_i = c;
    flash_ptr_i = p;
    nvm_addr_i = a;
    step;
    nvm_go_i = 1'b0;
    check(flash_op_o, c == 2'h1 && p[14:7] < APP_PAGES + BOOT_PAGES);
    check(eeprom_op_o, c[1]);
    if (c[1]) check(eeprom_whole_page_o, c == 2'h2);
    check({flash_page_number_o, flash_word_in_page_o}, p[14:0]);
    check(flash_boot_o, p[14]);
    check({eeprom_page_number_o, eeprom_byte_in_page_o}, a);
    step;
    check({flash_op_o, eeprom_op_o}, 2'h0);
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    t_id();
    t_lock();
    t_mem();
    t_burst(16'h2100, 4'h3, 2, 1, 8'hA0);
    t_burst(16'h1040, 4'h2, 3, 2, 8'hB0);
    t_conc();
    t_en();
    t_nvm(2'h1, 16'h4085, 10'h2A7);
    t_nvm(2'h1, 16'h4800, 10'h000);
    t_nvm(2'h2, 16'h0283, 10'h2A7);
    t_nvm(2'h3, 16'h017F, 10'h01F);
    t_nvm(2'h0, 16'h3F80, 10'h3E0);
    end_of_test();
  end
  initial begin
    // whole run is about 110 cycles; this is ample
    #100000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
